// ---- hw/sptb_checker.sv ----
`timescale 1ns/1ps
module sptb_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic enable_i,
    input wire logic [1:0] pattern_i,
    input wire logic rx_valid_i,
    input wire logic [31:0] rx_data_i,
    output logic [15:0] err_cnt_o,
    output logic [15:0] frm_cnt_o,
    output logic synced_o
);
    import sptb_pkg::*;
    logic [15:0] expect_r;
    logic [1:0] good_r;
    logic [31:0] fixed_w;
    logic is_count_w;
    logic mismatch_w;

    assign is_count_w = (pattern_i == SPTB_PAT_COUNT);
    always_comb begin
        case (pattern_i)
            2'h0: fixed_w = SPTB_PAT0;
            2'h1: fixed_w = SPTB_PAT1;
            default: fixed_w = SPTB_PAT2;
        endcase
    end
    assign mismatch_w = is_count_w ? (rx_data_i[15:0] != expect_r)
                                   : (rx_data_i != fixed_w);

    // counting sync: three correct consecutive counts
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i || !enable_i || !is_count_w) begin
            good_r <= 2'h0;
            expect_r <= 16'h0000;
        end else if (rx_valid_i) begin
            expect_r <= rx_data_i[15:0] + 16'h0001;
            if (!synced_o) begin // R7
                if (rx_data_i[15:0] == expect_r)
                    good_r <= good_r + 2'h1;
                else
                    good_r <= 2'h0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i || !enable_i || !is_count_w)
            synced_o <= 1'b0;
        else if (rx_valid_i && !synced_o && good_r == 2'h2
                 && rx_data_i[15:0] == expect_r)
            synced_o <= 1'b1; // R7
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) // R21
            err_cnt_o <= 16'h0000;
        else if (enable_i && rx_valid_i && mismatch_w
                 && (synced_o || !is_count_w) // R8
                 && err_cnt_o != SPTB_CNT_MAX) // R6
            err_cnt_o <= err_cnt_o + 16'h0001;
    end

    // frame count only for counting pattern, bumps on FFFFh
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) // R21
            frm_cnt_o <= 16'h0000;
        else if (enable_i && rx_valid_i && is_count_w // R5
                 && rx_data_i[15:0] == SPTB_CNT_MAX) // R9
            frm_cnt_o <= frm_cnt_o + 16'h0001;
    end
endmodule : sptb_checker

// ---- hw/sptb_pkg.sv ----
package sptb_pkg;
    localparam logic [11:0] SPTB_CSR_OFF = 12'h044;
    localparam logic [11:0] SPTB_ERR_OFF = 12'h048;
    localparam logic [11:0] SPTB_FRM_OFF = 12'h04C;
    localparam logic [11:0] SPTB_RXLO_OFF = 12'h050;
    localparam logic [11:0] SPTB_RXHI_OFF = 12'h054;
    localparam logic [31:0] SPTB_CSR_RST = 32'h0000_0000;
    localparam int SPTB_GEN_PAT_LSB = 30;
    localparam int SPTB_CHK_PAT_LSB = 28;
    localparam int SPTB_CLR_CNT_BIT = 25;
    localparam int SPTB_GEN_EN_BIT = 24;
    localparam int SPTB_CHK_EN_BIT = 23;
    localparam int SPTB_NEAR_LOOP_BIT = 20;
    localparam int SPTB_OOB_BYP_BIT = 19;
    localparam int SPTB_TAP_DIS_BIT = 18;
    localparam int SPTB_SCR_BYP_BIT = 17;
    localparam int SPTB_K285_BIT = 16;
    localparam int SPTB_RX_ACT_BIT = 15;
    localparam int SPTB_RX_TXO_BIT = 14;
    localparam int SPTB_RX_ALB_BIT = 13;
    localparam int SPTB_RX_SCB_BIT = 12;
    localparam int SPTB_RX_RET_BIT = 11;
    localparam int SPTB_RX_PRM_BIT = 10;
    localparam int SPTB_RX_AFE_BIT = 9;
    localparam int SPTB_SEND_BIT = 7;
    localparam int SPTB_TXO_BIT = 6;
    localparam int SPTB_AFE_BIT = 1;
    localparam int SPTB_RET_BIT = 3;
    localparam logic [31:0] SPTB_WMASK = 32'hF19F_007E;
    localparam logic [15:0] SPTB_CNT_MAX = 16'hFFFF;
    localparam logic [1:0] SPTB_SYNC_NEED = 2'h3;
    localparam logic [1:0] SPTB_PAT_COUNT = 2'h3;
    localparam logic [31:0] SPTB_PAT0 = 32'h4A4A_4A4A;
    localparam logic [31:0] SPTB_PAT1 = 32'h7E7E_7E7E;
    localparam logic [31:0] SPTB_PAT2 = 32'hB5B5_B5B5;
    localparam logic [31:0] SPTB_K285_WORD = 32'hBCBC_BCBC;
endpackage : sptb_pkg

// ---- hw/sptb_top.sv ----
`timescale 1ns/1ps
// Functional notes
// R1 - 32-bit per-port test register lets software send BIST Activate FIS.
// R2 - received BIST Activate FIS and its options reported in same register.
// R3 - far end commanded to retimed, analog loopback, or transmit-only.
// R4 - four patterns, meant for far-end retimed loopback only.
// R5 - patterns 0-2 fixed repeating words; frame counter unused.
// R6 - error count saturates at FFFFh, never wraps.
// R7 - counting pattern; errors flagged after three consecutive good counts.
// R8 - no counting sync means error counter stays zero.
// R9 - received FFFFh in counting pattern advances frame counter.
// R10 - software distrusts counting results on very bad links.
// R11 - bit 20 selects near-end loopback, default zero.
// R12 - bit 19 bypasses out-of-band processing.
// R13 - bit 18 forces test access port disabled.
// R14 - bit 17 bypasses scramblers and stops CONT insertion.
// R15 - bit 16 sends unbroken K28.5 stream regardless of other settings.
// R16 - bit 15 set once FIS received and port is in self-test.
// R17 - bit 14 transmit-only request; port sends the two captured words.
// R18 - bit 13 align-bypass option, meaningful with bit 14.
// R19 - bit 12 scrambling-bypass option, meaningful with bit 14.
// R20 - software sets bits 6:1 first; writing bit 7 sends FIS.
// R21 - writing bit 25 clears error and frame counts.
// R22 - bits 31:30 generator pattern, bits 29:28 checker pattern.
// R23 - bit 24 enables generator, bit 23 enables checker.
// R24 - all control and received flags reset to zero.
module sptb_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    output logic fis_send_o,
    output logic [5:0] fis_opts_o,
    input wire logic fis_sent_i,
    input wire logic fis_rx_i,
    input wire logic [5:0] fis_rx_opts_i,
    input wire logic [31:0] fis_rx_lo_i,
    input wire logic [31:0] fis_rx_hi_i,
    input wire logic link_reset_i,
    output logic near_loop_o,
    output logic oob_bypass_o,
    output logic tap_disable_o,
    output logic scr_bypass_o,
    output logic cont_inhibit_o,
    output logic tx_valid_o,
    output logic [31:0] tx_data_o,
    input wire logic rx_valid_i,
    input wire logic [31:0] rx_data_i
);
    import sptb_pkg::*;
    logic [31:0] ctl_r;
    logic [6:0] rxst_r;
    logic [31:0] rx_lo_r;
    logic [31:0] rx_hi_r;
    logic [15:0] gen_cnt_r;
    logic tx_sel_r;
    logic clr_r;
    logic [15:0] err_cnt_w;
    logic [15:0] frm_cnt_w;
    logic req_w;
    logic wr_w;
    logic hit_w;
    logic [31:0] wmask_w;
    logic [31:0] csr_w;
    logic [31:0] gen_word_w;

    assign req_w = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign hit_w = (wb_adr_i == SPTB_CSR_OFF) || (wb_adr_i == SPTB_ERR_OFF)
                   || (wb_adr_i == SPTB_FRM_OFF)
                   || (wb_adr_i == SPTB_RXLO_OFF)
                   || (wb_adr_i == SPTB_RXHI_OFF);
    assign wr_w = req_w && wb_we_i && (wb_adr_i == SPTB_CSR_OFF);
    assign wmask_w = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // single-cycle ack, err for unmapped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= req_w && hit_w;
            wb_err_o <= req_w && !hit_w;
        end
    end

    // control bits; bit 7 and 25 are self-clearing strobes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_r <= SPTB_CSR_RST; // R24
        end else if (wr_w) begin
            ctl_r <= (ctl_r & ~(wmask_w & SPTB_WMASK))
                     | (wb_dat_i & wmask_w & SPTB_WMASK); // R11 R22 R23 R3
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            clr_r <= 1'b0;
        else
            clr_r <= wr_w && wb_sel_i[3]
                     && wb_dat_i[SPTB_CLR_CNT_BIT]; // R21
    end

    // FIS send request held until link accepts
    always_ff @(posedge clk_i) begin
        if (rst_i)
            fis_send_o <= 1'b0;
        else if (wr_w && wb_sel_i[0] && wb_dat_i[SPTB_SEND_BIT])
            fis_send_o <= 1'b1; // R20 R1
        else if (fis_sent_i)
            fis_send_o <= 1'b0;
    end

    // options taken from register at send time
    always_ff @(posedge clk_i) begin
        if (rst_i)
            fis_opts_o <= 6'h00;
        else if (wr_w && wb_sel_i[0] && wb_dat_i[SPTB_SEND_BIT])
            fis_opts_o <= ctl_r[SPTB_TXO_BIT:SPTB_AFE_BIT]; // R20 R3
    end

    // received FIS flags; set wins over link reset clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rxst_r <= 7'h00; // R24
            rx_lo_r <= 32'h0000_0000;
            rx_hi_r <= 32'h0000_0000;
        end else if (fis_rx_i) begin
            rxst_r <= {1'b1, fis_rx_opts_i}; // R2 R16 R18 R19
            rx_lo_r <= fis_rx_lo_i; // R17
            rx_hi_r <= fis_rx_hi_i;
        end else if (link_reset_i) begin
            rxst_r <= 7'h00;
        end
    end

    // rxst_r: 6 active,5 txo,4 align,3 scr,2 ret,1 prim,0 afe
    always_comb begin
        csr_w = ctl_r;
        csr_w[SPTB_RX_ACT_BIT] = rxst_r[6]; // R16
        csr_w[SPTB_RX_TXO_BIT] = rxst_r[5]; // R17
        csr_w[SPTB_RX_ALB_BIT] = rxst_r[4]; // R18
        csr_w[SPTB_RX_SCB_BIT] = rxst_r[3]; // R19
        csr_w[SPTB_RX_RET_BIT] = rxst_r[2];
        csr_w[SPTB_RX_PRM_BIT] = rxst_r[1];
        csr_w[SPTB_RX_AFE_BIT] = rxst_r[0];
        csr_w[SPTB_SEND_BIT] = fis_send_o;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (req_w && !wb_we_i) begin
            case (wb_adr_i)
                SPTB_CSR_OFF: wb_dat_o <= csr_w; // R1
                SPTB_ERR_OFF: wb_dat_o <= {16'h0000, err_cnt_w};
                SPTB_FRM_OFF: wb_dat_o <= {16'h0000, frm_cnt_w};
                SPTB_RXLO_OFF: wb_dat_o <= rx_lo_r;
                SPTB_RXHI_OFF: wb_dat_o <= rx_hi_r;
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // near-end test controls
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            near_loop_o <= 1'b0;
            oob_bypass_o <= 1'b0;
            tap_disable_o <= 1'b0;
            scr_bypass_o <= 1'b0;
            cont_inhibit_o <= 1'b0;
        end else begin
            near_loop_o <= ctl_r[SPTB_NEAR_LOOP_BIT]; // R11
            oob_bypass_o <= ctl_r[SPTB_OOB_BYP_BIT]; // R12
            tap_disable_o <= ctl_r[SPTB_TAP_DIS_BIT]; // R13
            scr_bypass_o <= ctl_r[SPTB_SCR_BYP_BIT]; // R14
            cont_inhibit_o <= ctl_r[SPTB_SCR_BYP_BIT]; // R14
        end
    end

    // generator counting value
    always_ff @(posedge clk_i) begin
        if (rst_i || !ctl_r[SPTB_GEN_EN_BIT])
            gen_cnt_r <= 16'h0000;
        else
            gen_cnt_r <= gen_cnt_r + 16'h0001; // R7
    end

    // transmit-only alternates between the two captured words
    always_ff @(posedge clk_i) begin
        if (rst_i || !rxst_r[5])
            tx_sel_r <= 1'b0;
        else
            tx_sel_r <= !tx_sel_r; // R17
    end

    always_comb begin
        case (ctl_r[SPTB_GEN_PAT_LSB +: 2]) // R22 R4
            2'h0: gen_word_w = SPTB_PAT0; // R5
            2'h1: gen_word_w = SPTB_PAT1;
            2'h2: gen_word_w = SPTB_PAT2;
            default: gen_word_w = {16'h0000, gen_cnt_r};
        endcase
    end

    // transmit source, K28.5 highest priority
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_valid_o <= 1'b0;
            tx_data_o <= 32'h0000_0000;
        end else if (ctl_r[SPTB_K285_BIT]) begin
            tx_valid_o <= 1'b1;
            tx_data_o <= SPTB_K285_WORD; // R15
        end else if (rxst_r[6] && rxst_r[5]) begin
            tx_valid_o <= 1'b1;
            tx_data_o <= tx_sel_r ? rx_hi_r : rx_lo_r; // R17
        end else if (ctl_r[SPTB_GEN_EN_BIT]) begin
            tx_valid_o <= 1'b1;
            tx_data_o <= gen_word_w; // R23
        end else begin
            tx_valid_o <= 1'b0;
            tx_data_o <= 32'h0000_0000;
        end
    end

    sptb_checker u_chk (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(clr_r),
        .enable_i(ctl_r[SPTB_CHK_EN_BIT]), // R23
        .pattern_i(ctl_r[SPTB_CHK_PAT_LSB +: 2]), // R22
        .rx_valid_i(rx_valid_i),
        .rx_data_i(rx_data_i),
        .err_cnt_o(err_cnt_w),
        .frm_cnt_o(frm_cnt_w),
        .synced_o()
    );
endmodule : sptb_top

// ---- test/sptb_far_model.sv ----
`timescale 1ns/1ps
module sptb_far_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic fis_send_i,
    output logic fis_sent_o,
    input wire logic tx_valid_i,
    input wire logic [31:0] tx_data_i,
    input wire logic err_i,
    input wire logic cnt_i,
    output logic rx_valid_o,
    output logic [31:0] rx_data_o
);
    logic [2:0] wait_r;
    logic [15:0] seq_r;
    // takes a send request some cycles after it rises
    always_ff @(posedge clk_i) begin
        if (rst_i || !fis_send_i || fis_sent_o) begin
            wait_r <= 3'h0;
            fis_sent_o <= 1'b0;
        end else begin
            wait_r <= wait_r + 3'h1;
            fis_sent_o <= wait_r == 3'h3;
        end
    end
    // retimed loopback, or a counting run from FFF0
    always_ff @(posedge clk_i) begin
        if (rst_i || !cnt_i) begin
            seq_r <= 16'hFFF0;
        end else begin
            seq_r <= seq_r + 16'h1;
        end
        rx_valid_o <= cnt_i || tx_valid_i;
        // idle words are garbled; err_i flips bit 0
        rx_data_o <= !(cnt_i || tx_valid_i) ? ~rx_data_o :
            (cnt_i ? {16'h0, seq_r} : tx_data_i) ^ {31'h0, err_i};
    end
endmodule : sptb_far_model

// ---- test/sptb_props.sv ----
`timescale 1ns/1ps
module sptb_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    input wire logic fis_send_o,
    input wire logic fis_sent_i,
    input wire logic near_loop_o,
    input wire logic scr_bypass_o,
    input wire logic cont_inhibit_o,
    input wire logic tx_valid_o,
    input wire logic [31:0] tx_data_o
);
    import sptb_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic tk, wr, mapped;
    assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign wr = tk && wb_we_i && wb_adr_i == SPTB_CSR_OFF;
    assign mapped = wb_adr_i inside {SPTB_CSR_OFF, SPTB_ERR_OFF,
        SPTB_FRM_OFF, SPTB_RXLO_OFF, SPTB_RXHI_OFF};
    a_bus_answer: assert property (tk |=> wb_ack_o ^ wb_err_o)
        else $error("request not answered one cycle later");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_unmapped_err: assert property (tk && !mapped |=> wb_err_o)
        else $error("unmapped access without error");
    a_near_loop_copy: assert property (wr && wb_sel_i[2] |->
        ##2 near_loop_o == $past(wb_dat_i[20], 2))
        else $error("near loopback not copied from write");
    a_scr_cont_tie: assert property (scr_bypass_o == cont_inhibit_o)
        else $error("scrambler bypass and cont inhibit differ");
    a_send_hold: assert property (fis_send_o && !fis_sent_i |=> fis_send_o)
        else $error("send request dropped before taken");
    a_send_start: assert property (wr && wb_sel_i[0] && wb_dat_i[7] |->
        ##[1:2] fis_send_o)
        else $error("send write raised no request");
    a_k285_stream: assert property (wr && wb_sel_i[2] && wb_dat_i[16] |->
        ##3 (tx_valid_o && tx_data_o == SPTB_K285_WORD) [*2])
        else $error("comma stream not sent");
    a_reset_quiet: assert property ($fell(rst_i) |->
        !fis_send_o && !near_loop_o && !tx_valid_o)
        else $error("output active after reset");
    cover property (wr && wb_dat_i[7]);
    cover property (wb_err_o);
    cover property (fis_sent_i);
endmodule : sptb_props

bind sptb_top sptb_props props_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .wb_err_o,
    .fis_send_o, .fis_sent_i, .near_loop_o, .scr_bypass_o,
    .cont_inhibit_o, .tx_valid_o, .tx_data_o);

// ---- test/sptb_tb_top.sv ----
`timescale 1ns/1ps
module sptb_tb_top;
    import sptb_pkg::*;
    localparam logic [31:0] LO = 32'h1357_9BDF;
    localparam logic [31:0] HI = 32'h2468_ACE0;
    logic clk_i, rst_i, cyc, stb, we, ack, err, fsend, fsent, frx, lrst;
    logic txv, rxv, inj, cnt_on, got_err;
    logic [11:0] adr;
    logic [4:0] nl;
    logic [5:0] opts, ropt;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, txd, rxd, got, w0;
    logic [7:0] modes [3] = '{8'h02, 8'h08, 8'h40};
    int failures, checks_done, cycles, n;
    sptb_top dut_u (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
        .fis_send_o(fsend), .fis_opts_o(opts), .fis_sent_i(fsent),
        .fis_rx_i(frx), .fis_rx_opts_i(ropt), .fis_rx_lo_i(LO),
        .fis_rx_hi_i(HI), .link_reset_i(lrst), .near_loop_o(nl[4]),
        .oob_bypass_o(nl[3]), .tap_disable_o(nl[2]),
        .scr_bypass_o(nl[1]), .cont_inhibit_o(nl[0]), .tx_valid_o(txv),
        .tx_data_o(txd), .rx_valid_i(rxv), .rx_data_i(rxd));
    sptb_far_model far_u (.clk_i, .rst_i, .fis_send_i(fsend),
        .fis_sent_o(fsent), .tx_valid_i(txv), .tx_data_i(txd),
        .err_i(inj), .cnt_i(cnt_on), .rx_valid_o(rxv), .rx_data_o(rxd));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask : check
    task automatic wb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1 && err !== 1'b1) @(posedge clk_i);
        got = rdat;
        got_err = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        check(got, e);
    endtask : rd
    task automatic final_report;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : final_report
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 90000) begin
            failures++;
            final_report();
        end
    end
    initial begin
        {rst_i, cyc, stb, we, frx, lrst, inj, cnt_on} <= 8'h80;
        adr <= 12'h0;
        wdat <= 32'h0;
        sel <= 4'hF;
        ropt <= 6'h2A;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(SPTB_CSR_OFF, SPTB_CSR_RST);
        wb(1'b0, 12'h0FC, 32'h0);
        check({31'h0, got_err}, 32'h1);
        wb(1'b1, SPTB_CSR_OFF, 32'h001F_FE00);
        rd(SPTB_CSR_OFF, 32'h001F_0000);
        check({27'h0, nl}, 32'h1F);
        check({txv, txd[30:0]}, SPTB_K285_WORD | 32'h8000_0000);
        wb(1'b1, SPTB_CSR_OFF, 32'h0);
        check({27'h0, nl}, 32'h0);
        $display("test near end done");
        foreach (modes[i]) begin
            wb(1'b1, SPTB_CSR_OFF, {24'h0, modes[i]});
            wb(1'b1, SPTB_CSR_OFF, {24'h0, modes[i] | 8'h80});
            check({31'h0, fsend}, 32'h1);
            check({26'h0, opts}, {26'h0, modes[i][6:1]});
            for (n = 0; fsend !== 1'b0 && n < 50; n++) @(posedge clk_i);
            rd(SPTB_CSR_OFF, {24'h0, modes[i]});
        end
        $display("test send done");
        frx <= 1'b1;
        @(posedge clk_i);
        frx <= 1'b0;
        @(posedge clk_i);
        rd(SPTB_CSR_OFF, 32'h0000_D440);
        rd(SPTB_RXLO_OFF, LO);
        rd(SPTB_RXHI_OFF, HI);
        w0 = txd;
        @(posedge clk_i);
        check(w0 ^ txd, LO ^ HI);
        lrst <= 1'b1;
        @(posedge clk_i);
        lrst <= 1'b0;
        rd(SPTB_CSR_OFF, 32'h0000_0040);
        $display("test receive done");
        for (int p = 0; p < 3; p++) begin
            wb(1'b1, SPTB_CSR_OFF, {p[1:0], p[1:0], 28'h380_0000});
            repeat (10) @(posedge clk_i);
            inj <= 1'b1;
            repeat (3) @(posedge clk_i);
            inj <= 1'b0;
            repeat (10) @(posedge clk_i);
            rd(SPTB_ERR_OFF, 32'h3);
            rd(SPTB_FRM_OFF, 32'h0);
            sel <= 4'h7;
            wb(1'b1, SPTB_CSR_OFF, 32'h0200_0000);
            rd(SPTB_ERR_OFF, 32'h3);
            sel <= 4'hF;
            wb(1'b1, SPTB_CSR_OFF, 32'h0200_0000);
            rd(SPTB_ERR_OFF, 32'h0);
        end
        wb(1'b1, SPTB_CSR_OFF, 32'h3380_0000);
        repeat (40) @(posedge clk_i);
        rd(SPTB_ERR_OFF, 32'h0);
        wb(1'b1, SPTB_CSR_OFF, 32'h1380_0000);
        repeat (65600) @(posedge clk_i);
        rd(SPTB_ERR_OFF, 32'h0000_FFFF);
        $display("test fixed patterns done");
        wb(1'b1, SPTB_CSR_OFF, 32'h3280_0000);
        {cnt_on, inj} <= 2'h3;
        repeat (2) @(posedge clk_i);
        inj <= 1'b0;
        repeat (6) @(posedge clk_i);
        rd(SPTB_ERR_OFF, 32'h0);
        inj <= 1'b1;
        @(posedge clk_i);
        inj <= 1'b0;
        repeat (4) @(posedge clk_i);
        cnt_on <= 1'b0;
        repeat (5) @(posedge clk_i);
        rd(SPTB_ERR_OFF, 32'h2);
        rd(SPTB_FRM_OFF, 32'h1);
        $display("test counting done");
        final_report();
    end
endmodule : sptb_tb_top
